//--- bench/mer_bus_partner.sv
// System bus side model: keeps accesses outstanding and reports read faults.
// Assumes one request pulse per access, synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mer_bus_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Access request
  input wire logic acc_req,
  input wire logic [1:0] acc_fault,
  input wire logic [7:0] acc_len,
  // Bus results
  output logic outstanding_busy,
  output logic bus_timeout,
  output logic bus_error
);
  logic [7:0] left;

  // Other accesses stay outstanding for acc_len cycles after the faulting one.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      left <= 8'h00;
    end else if (acc_req) begin
      left <= acc_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  assign outstanding_busy = (left != 8'h00);

  always_ff @(posedge clk_sys) begin
    bus_timeout <= acc_req & acc_fault[0] & ~sys_rst;
    bus_error <= acc_req & acc_fault[1] & ~sys_rst;
  end
endmodule : mer_bus_partner
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench of the memory error reporting core.
// Assumes the partner model and the core's package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, sys_rst, reg_wr, reg_rd, ec_check, tag_check, ecc_fill, err_priv;
  logic [7:0] reg_addr, acc_len;
  logic [63:0] reg_wdata, reg_rdata, d;
  logic [127:0] ec_data, out_data, r;
  logic [15:0] ec_par, out_par;
  logic [24:0] tag_bits;
  logic [3:0] tag_par, b;
  logic [4:0] ev;
  logic [40:0] err_addr;
  logic busy, retn_pending, probe_active, membar_req, acc_req, bus_timeout, bus_error;
  logic [1:0] acc_fault;
  logic fatal, t_ia, t_da, t_ce, t_bar, kill, fbe, fbp, ice, dce, mdone;
  logic [8:0] tt;
  logic [5:0] tp;
  mer_pkg::mer_kind_type ec_kind, sys_kind, k;
  int mismatches, cmp_count, cycles, seed, n;

  mer_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ec_data(ec_data), .ec_par(ec_par), .ec_check(ec_check), .ec_kind(ec_kind),
    .tag_bits(tag_bits), .tag_par(tag_par), .tag_check(tag_check), .out_data(out_data),
    .out_par(out_par), .sys_addr_par_err(ev[2]), .bus_timeout(bus_timeout),
    .bus_error(bus_error), .buffer_par_err(ev[3]), .ecc_ue(ev[1]), .ecc_ce(ev[0]),
    .ecc_fill(ecc_fill), .ivec_ue(ev[4]), .sys_kind(sys_kind), .err_priv(err_priv),
    .err_addr(err_addr), .outstanding_busy(busy), .retn_pending(retn_pending),
    .probe_active(probe_active), .membar_req(membar_req), .fatal_error_reply(fatal),
    .trap_inst_access(t_ia), .trap_data_access(t_da), .trap_corrected(t_ce),
    .trap_type_code(tt), .trap_priority(tp), .trap_at_barrier(t_bar), .kill_fetch(kill),
    .force_bad_ecc(fbe), .force_bad_parity(fbp), .icache_enable_bit(ice),
    .dcache_enable_bit(dce), .membar_done(mdone));

  mer_bus_partner partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .acc_req(acc_req),
    .acc_fault(acc_fault), .acc_len(acc_len), .outstanding_busy(busy),
    .bus_timeout(bus_timeout), .bus_error(bus_error));

  // ----------------------------------------
  // Expectations, compares and bus cycles
  // ----------------------------------------
  function automatic logic [15:0] par16(input logic [127:0] v);
    for (int j = 0; j < 16; j++) begin
      par16[j] = ^v[8*j +: 8];
    end
  endfunction : par16

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [63:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [63:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic fire(input logic [4:0] bits);
    @(posedge clk_sys);
    ev <= bits;
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask : fire

  task automatic ec_send(input mer_pkg::mer_kind_type kd, input logic [3:0] bad);
    r = {$urandom, $urandom, $urandom, $urandom};
    @(posedge clk_sys);
    ec_data <= r;
    ec_par <= par16(r) ^ (16'h0001 << bad);
    ec_kind <= kd;
    ec_check <= 1'b1;
    @(posedge clk_sys);
    ec_check <= 1'b0;
  endtask : ec_send

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_wr, reg_rd, ec_check, tag_check, ecc_fill, err_priv, acc_req, membar_req} = '0;
    {reg_addr, reg_wdata, ec_data, ec_par, tag_bits, tag_par, out_data, ev} = '0;
    {retn_pending, probe_active, acc_fault, acc_len, err_addr} = '0;
    ec_kind = mer_pkg::MER_KIND_DATA;
    sys_kind = mer_pkg::MER_KIND_DATA;
    seed = $urandom(94127);
    sys_rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    err_addr <= 41'({$urandom, $urandom});
    rd(mer_pkg::MER_OFS_ENABLE, d);
    chk_val(d, 64'h0);
    rd(mer_pkg::MER_OFS_LSU, d);
    chk_val(d, 64'h0);
    rd(8'h20, d);
    chk_val(d, 64'h0);
    wr(mer_pkg::MER_OFS_STATUS, '1);
    rd(mer_pkg::MER_OFS_STATUS, d);
    chk_val(d & 64'h1_FFF0_0000, 64'h0);
    for (int i = 0; i < 4; i++) begin
      r[2:0] = 3'($urandom);
      wr(mer_pkg::MER_OFS_ENABLE, {61'h0, r[2:0]});
      rd(mer_pkg::MER_OFS_ENABLE, d);
      chk_val(d, {61'h0, r[2:0]});
    end
    for (int i = 0; i < 2; i++) begin
      wr(mer_pkg::MER_OFS_ENABLE, {63'h0, i[0]});
      wr(mer_pkg::MER_OFS_STATUS, '1);
      fire(5'h01);
      #1;
      chk_flag(t_ce, i[0]);
      chk_val({49'h0, tp, tt}, i[0] ? {49'h0, 6'h21, 9'h063} : 64'h0);
      rd(mer_pkg::MER_OFS_STATUS, d);
      chk_val(d & 64'h10_0000, 64'h10_0000);
      wr(mer_pkg::MER_OFS_ENABLE, {61'h0, i[0], 2'h0});
      fire(5'h04);
      #1;
      chk_flag(fatal, i[0]);
      rd(mer_pkg::MER_OFS_STATUS, d);
      chk_val(d & 64'h4000_0000, 64'h4000_0000);
    end
    wr(mer_pkg::MER_OFS_ENABLE, 64'h2);
    wr(mer_pkg::MER_OFS_STATUS, '1);
    r[24:0] = 25'($urandom);
    @(posedge clk_sys);
    tag_bits <= r[24:0];
    tag_par <= {r[24], ^r[23:16], ^r[15:8], ^r[7:0]} ^ 4'h2;
    tag_check <= 1'b1;
    @(posedge clk_sys);
    tag_check <= 1'b0;
    tick(1);
    chk_flag(fatal, 1'b1);
    rd(mer_pkg::MER_OFS_STATUS, d);
    chk_val(d & 64'h200F_0000, 64'h2002_0000);
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? mer_pkg::MER_KIND_WBACK :
          (i == 1) ? mer_pkg::MER_KIND_SNOOP :
          (i == 2) ? mer_pkg::MER_KIND_INSTR : mer_pkg::MER_KIND_DATA;
      wr(mer_pkg::MER_OFS_STATUS, '1);
      b = 4'($urandom);
      ec_send(k, b);
      tick(1);
      chk_flag(fbe, i < 2);
      chk_flag(t_da, i == 0);
      chk_val({58'h0, tp}, (i == 0) ? 64'h21 : 64'h0);
      chk_flag(kill, i == 2);
      rd(mer_pkg::MER_OFS_STATUS, d);
      chk_val(d & 64'hFFFF, 64'h1 << b);
    end
    tick(4);
    for (int i = 0; i < 2; i++) begin
      wr(mer_pkg::MER_OFS_LSU, 64'h3);
      wr(mer_pkg::MER_OFS_STATUS, '1);
      @(posedge clk_sys);
      acc_req <= 1'b1;
      acc_fault <= i[0] ? 2'h2 : 2'h1;
      acc_len <= 8'h04;
      @(posedge clk_sys);
      acc_req <= 1'b0;
      fire(5'h02);
      #1;
      chk_flag(dce | ice, 1'b0);
      chk_flag(t_da, 1'b0);
      n = 0;
      while (t_da !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      chk_flag(t_da, 1'b1);
      chk_flag(busy, 1'b0);
      rd(mer_pkg::MER_OFS_STATUS, d);
      chk_val(d & 64'hC20_0000, i[0] ? 64'h420_0000 : 64'h820_0000);
    end
    wr(mer_pkg::MER_OFS_STATUS, '1);
    sys_kind <= mer_pkg::MER_KIND_INSTR;
    {probe_active, retn_pending, ecc_fill, err_priv} <= 4'hF;
    fire(5'h02);
    #1;
    chk_flag(kill, 1'b1);
    chk_flag(fbp, 1'b1);
    tick(3);
    chk_flag(t_ia, 1'b0);
    @(posedge clk_sys);
    retn_pending <= 1'b0;
    tick(1);
    chk_flag(t_ia, 1'b1);
    chk_flag(t_bar, 1'b1);
    rd(mer_pkg::MER_OFS_ADDRESS, d);
    chk_val(d, 64'(err_addr));
    rd(mer_pkg::MER_OFS_STATUS, d);
    chk_val(d & 64'h8020_0000, 64'h8020_0000);
    wr(mer_pkg::MER_OFS_STATUS, '1);
    fire(5'h18);
    tick(1);
    chk_flag(t_da, 1'b1);
    chk_flag(t_ia, 1'b0);
    @(posedge clk_sys);
    sys_kind <= mer_pkg::MER_KIND_DATA;
    {probe_active, ecc_fill, err_priv} <= 3'h0;
    @(posedge clk_sys);
    membar_req <= 1'b1;
    n = 0;
    tick(1);
    while (mdone !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk_flag(mdone, 1'b1);
    @(posedge clk_sys);
    membar_req <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      out_data <= {$urandom, $urandom, $urandom, $urandom};
      tick(1);
      chk_val({48'h0, out_par}, {48'h0, par16(out_data)});
    end
    rd(mer_pkg::MER_OFS_STATUS, r[63:0]);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(mer_pkg::MER_OFS_STATUS, d);
    chk_val(d, r[63:0]);
    rd(mer_pkg::MER_OFS_ENABLE, d);
    chk_val(d, 64'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

//--- core/mer_byte_parity.sv
// Byte parity generator and checker with registered outputs.
// Assumes even parity: each parity bit makes its byte plus itself XOR to zero.
`timescale 1ns/1ps
`default_nettype none
module mer_byte_parity #(
  parameter int NBYTES = 16
) (
  // Clock
  input wire logic clk_sys,
  // Checked path
  input wire logic [NBYTES*8-1:0] chk_data,
  input wire logic [NBYTES-1:0] chk_par,
  input wire logic chk_valid,
  output logic [NBYTES-1:0] syndrome,
  output logic err,
  // Generated path
  input wire logic [NBYTES*8-1:0] gen_data,
  output logic [NBYTES-1:0] gen_par
);

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NBYTES; i++) begin
      syndrome[i] <= chk_valid & ((^chk_data[i*8 +: 8]) ^ chk_par[i]);
      gen_par[i] <= ^gen_data[i*8 +: 8];
    end
  end

  always_ff @(posedge clk_sys) begin
    err <= 1'b0;
    for (int i = 0; i < NBYTES; i++) begin
      if (chk_valid && ((^chk_data[i*8 +: 8]) ^ chk_par[i])) begin
        err <= 1'b1;
      end
    end
  end

endmodule : mer_byte_parity
`default_nettype wire

//--- core/mer_core.sv
// Memory error detector, logger and trap sequencer.
// Assumes event inputs are one-cycle pulses synchronous to clk_sys and that
// the pipeline reports its outstanding accesses and pending returns as levels.
`timescale 1ns/1ps
`default_nettype none

module mer_core #(
  parameter int ADDR_W = 41
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  // External cache data and tag paths
  input wire logic [127:0] ec_data,
  input wire logic [15:0] ec_par,
  input wire logic ec_check,
  input wire mer_pkg::mer_kind_type ec_kind,
  input wire logic [24:0] tag_bits,
  input wire logic [3:0] tag_par,
  input wire logic tag_check,
  input wire logic [127:0] out_data,
  output logic [15:0] out_par,
  // System side events
  input wire logic sys_addr_par_err,
  input wire logic bus_timeout,
  input wire logic bus_error,
  input wire logic buffer_par_err,
  input wire logic ecc_ue,
  input wire logic ecc_ce,
  input wire logic ecc_fill,
  input wire logic ivec_ue,
  input wire mer_pkg::mer_kind_type sys_kind,
  input wire logic err_priv,
  input wire logic [ADDR_W-1:0] err_addr,
  // Pipeline state
  input wire logic outstanding_busy,
  input wire logic retn_pending,
  input wire logic probe_active,
  input wire logic membar_req,
  // Results
  output logic fatal_error_reply,
  output logic trap_inst_access,
  output logic trap_data_access,
  output logic trap_corrected,
  output logic [8:0] trap_type_code,
  output logic [5:0] trap_priority,
  output logic trap_at_barrier,
  output logic kill_fetch,
  output logic force_bad_ecc,
  output logic force_bad_parity,
  output logic icache_enable_bit,
  output logic dcache_enable_bit,
  output logic membar_done
);

  // ----------------------------------------
  // Parity checkers
  // ----------------------------------------
  logic [15:0] dsyn;
  logic [3:0] tsyn;
  logic derr;
  logic terr;
  mer_pkg::mer_kind_type kind_q;

  mer_byte_parity #(.NBYTES(16)) u_data_par (
    .clk_sys(clk_sys),
    .chk_data(ec_data),
    .chk_par(ec_par),
    .chk_valid(ec_check),
    .syndrome(dsyn),
    .err(derr),
    .gen_data(out_data),
    .gen_par(out_par)
  );

  mer_byte_parity #(.NBYTES(4)) u_tag_par (
    .clk_sys(clk_sys),
    .chk_data({7'h00, tag_bits}),
    .chk_par(tag_par),
    .chk_valid(tag_check),
    .syndrome(tsyn),
    .err(terr),
    .gen_data(32'h0000_0000),
    .gen_par()
  );

  // The access kind follows the checker's one-cycle delay.
  always_ff @(posedge clk_sys) begin
    kind_q <= ec_kind;
  end

  // ----------------------------------------
  // Event classification
  // ----------------------------------------
  logic [10:0] ev;
  logic defer_any;
  logic ec_instr;
  logic first_instr;

  assign ec_instr = (kind_q == mer_pkg::MER_KIND_INSTR);

  always_comb begin
    ev = 11'h000;
    ev[mer_pkg::MER_EV_ISAP] = sys_addr_par_err;
    ev[mer_pkg::MER_EV_ETP] = terr;
    ev[mer_pkg::MER_EV_IVUE] = ivec_ue;
    ev[mer_pkg::MER_EV_TO] = bus_timeout;
    ev[mer_pkg::MER_EV_BERR] = bus_error;
    ev[mer_pkg::MER_EV_LDP] = buffer_par_err;
    ev[mer_pkg::MER_EV_CP] = derr && (kind_q == mer_pkg::MER_KIND_SNOOP);
    ev[mer_pkg::MER_EV_WP] = derr && (kind_q == mer_pkg::MER_KIND_WBACK);
    ev[mer_pkg::MER_EV_EDP] = derr && (kind_q inside {mer_pkg::MER_KIND_INSTR,
                                                      mer_pkg::MER_KIND_DATA});
    // Any beat of a fill block counts, not just the requested word.
    ev[mer_pkg::MER_EV_UE] = ecc_ue;
    ev[mer_pkg::MER_EV_CE] = ecc_ce;
  end

  // Writeback and snoop parity are deliberately outside the deferred class.
  assign defer_any = ev[mer_pkg::MER_EV_EDP] | ev[mer_pkg::MER_EV_UE] |
                     ev[mer_pkg::MER_EV_IVUE] | ev[mer_pkg::MER_EV_TO] |
                     ev[mer_pkg::MER_EV_BERR] | ev[mer_pkg::MER_EV_LDP];

  // Cache parity outranks a same-cycle system error when picking the kind.
  assign first_instr = ev[mer_pkg::MER_EV_EDP] ? ec_instr :
                       (!ev[mer_pkg::MER_EV_IVUE] && sys_kind == mer_pkg::MER_KIND_INSTR);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [2:0] err_enable;
  logic [32:0] fault_status_log;
  logic [ADDR_W-1:0] fault_address_log;
  logic wr_status;
  logic [12:0] clr;
  logic [10:0] sticky_kept;
  logic [10:0] sticky_next;
  logic en_ap;
  logic en_uc;
  logic en_ce;

  assign en_ap = err_enable[mer_pkg::MER_EN_ADDR_PAR];
  assign en_uc = err_enable[mer_pkg::MER_EN_UNCORR];
  assign en_ce = err_enable[mer_pkg::MER_EN_CORR];
  assign wr_status = reg_wr && (reg_addr == mer_pkg::MER_OFS_STATUS);
  assign clr = wr_status ? reg_wdata[32:20] : 13'h0000;
  assign sticky_kept = fault_status_log[30:20] & ~clr[10:0];
  assign sticky_next = sticky_kept | ev;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      err_enable <= mer_pkg::MER_ENABLE_RST;
    end else if (reg_wr && reg_addr == mer_pkg::MER_OFS_ENABLE) begin
      err_enable <= reg_wdata[2:0];
    end
  end

  // No reset here: the log must explain a fatal error after the system reset.
  // A clear and a new error in one cycle leave the new error logged.
  always_ff @(posedge clk_sys) begin
    fault_status_log[30:20] <= sticky_next;
    fault_status_log[mer_pkg::MER_ST_MULTI] <=
      (fault_status_log[mer_pkg::MER_ST_MULTI] & ~clr[12]) |
      (|(ev[10:1] & sticky_kept[10:1]));
    fault_status_log[mer_pkg::MER_ST_PRIV] <=
      (fault_status_log[mer_pkg::MER_ST_PRIV] & ~clr[11]) | ((|ev) & err_priv);
    if (terr && !sticky_kept[mer_pkg::MER_EV_ETP]) begin
      fault_status_log[19:16] <= tsyn;
    end else if (!sticky_next[mer_pkg::MER_EV_ETP]) begin
      fault_status_log[19:16] <= 4'h0;
    end
    if (derr && !(|sticky_kept[4:2])) begin
      fault_status_log[15:0] <= dsyn;
    end else if (!(|sticky_next[4:2])) begin
      fault_status_log[15:0] <= 16'h0000;
    end
  end

  // The address of the first error since the last clear is kept.
  always_ff @(posedge clk_sys) begin
    if ((|ev) && !(|sticky_kept)) begin
      fault_address_log <= err_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      icache_enable_bit <= 1'b0;
      dcache_enable_bit <= 1'b0;
    end else if (defer_any) begin
      icache_enable_bit <= 1'b0;
      dcache_enable_bit <= 1'b0;
    end else if (reg_wr && reg_addr == mer_pkg::MER_OFS_LSU) begin
      icache_enable_bit <= reg_wdata[mer_pkg::MER_LSU_ICACHE];
      dcache_enable_bit <= reg_wdata[mer_pkg::MER_LSU_DCACHE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 64'h0000_0000_0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        mer_pkg::MER_OFS_ENABLE: reg_rdata <= {61'h0, err_enable};
        mer_pkg::MER_OFS_STATUS: reg_rdata <= {31'h0, fault_status_log};
        mer_pkg::MER_OFS_ADDRESS: reg_rdata <= 64'(fault_address_log);
        mer_pkg::MER_OFS_LSU: reg_rdata <= {62'h0, dcache_enable_bit, icache_enable_bit};
        default: reg_rdata <= 64'h0000_0000_0000_0000;
      endcase
    end else begin
      reg_rdata <= 64'h0000_0000_0000_0000;
    end
  end

  // ----------------------------------------
  // Deferred trap sequencer
  // ----------------------------------------
  mer_pkg::mer_state_type state;
  mer_pkg::mer_state_type next_state;
  logic pend_instr;
  logic pend_probe;
  logic deliver;

  // Traps wait for every outstanding access and for a pending trap return.
  assign deliver = (state == mer_pkg::MER_DRAIN) && !outstanding_busy &&
                   !retn_pending;

  always_comb begin
    next_state = state;
    unique case (state)
      mer_pkg::MER_IDLE: if (defer_any && en_uc) next_state = mer_pkg::MER_DRAIN;
      mer_pkg::MER_DRAIN: if (deliver) next_state = mer_pkg::MER_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= mer_pkg::MER_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Only the first error picks the trap kind; later ones arriving in MER_DRAIN leave pend_instr and pend_probe unchanged.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_instr <= 1'b0;
      pend_probe <= 1'b0;
    end else if (state == mer_pkg::MER_IDLE && defer_any && en_uc) begin
      pend_instr <= first_instr;
      pend_probe <= probe_active;
    end
  end

  // The saved counters are not touched here; only the probe marker is given.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      trap_inst_access <= 1'b0;
      trap_data_access <= 1'b0;
      trap_at_barrier <= 1'b0;
      trap_priority <= 6'h00;
    end else begin
      trap_inst_access <= deliver && pend_instr;
      trap_data_access <= (deliver && !pend_instr) ||
                          (ev[mer_pkg::MER_EV_WP] && en_uc);
      trap_at_barrier <= deliver && pend_probe;
      trap_priority <= ((ev[mer_pkg::MER_EV_WP] && en_uc) || (ev[mer_pkg::MER_EV_CE] && en_ce)) ?
                       mer_pkg::MER_PRIO_DISRUPT : 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      trap_corrected <= 1'b0;
      trap_type_code <= 9'h000;
    end else begin
      trap_corrected <= ev[mer_pkg::MER_EV_CE] && en_ce;
      trap_type_code <= (ev[mer_pkg::MER_EV_CE] && en_ce) ?
                        mer_pkg::MER_TT_CORRECTED : 9'h000;
    end
  end

  // ----------------------------------------
  // Immediate responses
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fatal_error_reply <= 1'b0;
      kill_fetch <= 1'b0;
      force_bad_ecc <= 1'b0;
      force_bad_parity <= 1'b0;
      membar_done <= 1'b0;
    end else begin
      fatal_error_reply <= (terr && en_uc) || (sys_addr_par_err && en_ap);
      // Marking at detection keeps the bad instruction from ever executing.
      kill_fetch <= (derr && ec_instr) ||
                    (ecc_ue && sys_kind == mer_pkg::MER_KIND_INSTR);
      force_bad_ecc <= ev[mer_pkg::MER_EV_WP] | ev[mer_pkg::MER_EV_CP];
      // Correction needs no stall; only uncorrectable fills are poisoned.
      force_bad_parity <= ecc_ue && ecc_fill;
      membar_done <= membar_req && !membar_done && state == mer_pkg::MER_IDLE &&
                     !defer_any && !outstanding_busy;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_fatal;
    @(posedge clk_sys) disable iff (sys_rst)
      (sys_addr_par_err && en_ap) |=> fatal_error_reply;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal reply missing");

  property p_logged;
    @(posedge clk_sys) disable iff (sys_rst)
      (|ev) |=> ((fault_status_log[30:20] & $past(ev)) == $past(ev));
  endproperty
  a_logged: assert property (p_logged) else $error("error not logged");

  property p_cache_off;
    @(posedge clk_sys) disable iff (sys_rst)
      defer_any |=> (!icache_enable_bit && !dcache_enable_bit);
  endproperty
  a_cache_off: assert property (p_cache_off) else $error("cache left on");

  property p_drain;
    @(posedge clk_sys) disable iff (sys_rst)
      outstanding_busy |=> !trap_inst_access;
  endproperty
  a_drain: assert property (p_drain) else $error("trap while busy");

  property p_corrected;
    @(posedge clk_sys) disable iff (sys_rst)
      (ecc_ce && en_ce) |=> (trap_corrected && trap_type_code == 9'h063 &&
                             trap_priority == 6'h21);
  endproperty
  a_corrected: assert property (p_corrected) else $error("bad corrected trap");

  property p_wback;
    @(posedge clk_sys) disable iff (sys_rst)
      ev[mer_pkg::MER_EV_WP] |=> force_bad_ecc ##0 (trap_data_access || !$past(en_uc));
  endproperty
  a_wback: assert property (p_wback) else $error("writeback not poisoned");

  property p_membar;
    @(posedge clk_sys) disable iff (sys_rst)
      membar_done |-> ($past(state) == mer_pkg::MER_IDLE && !$past(defer_any));
  endproperty
  a_membar: assert property (p_membar) else $error("barrier passed error");

  property p_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_status && reg_wdata[21] && !ev[mer_pkg::MER_EV_UE]) |=> !fault_status_log[21];
  endproperty
  a_clear: assert property (p_clear) else $error("sticky bit not cleared");

  property p_kill;
    @(posedge clk_sys) disable iff (sys_rst)
      (ecc_ue && sys_kind == mer_pkg::MER_KIND_INSTR) |=> kill_fetch;
  endproperty
  a_kill: assert property (p_kill) else $error("fetch not killed");

  property p_return;
    @(posedge clk_sys) disable iff (sys_rst)
      retn_pending |=> !trap_inst_access;
  endproperty
  a_return: assert property (p_return) else $error("trap before return");

endmodule : mer_core
`default_nettype wire

//--- core/mer_pkg.sv
// Shared constants and types of the memory error reporting block.
// Assumes a 64-bit register port and a 250 MHz processor clock.
package mer_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] MER_OFS_ENABLE = 8'h00;
  localparam logic [7:0] MER_OFS_STATUS = 8'h08;
  localparam logic [7:0] MER_OFS_ADDRESS = 8'h10;
  localparam logic [7:0] MER_OFS_LSU = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MER_EN_ADDR_PAR = 2;
  localparam int MER_EN_UNCORR = 1;
  localparam int MER_EN_CORR = 0;
  localparam int MER_LSU_DCACHE = 1;
  localparam int MER_LSU_ICACHE = 0;
  localparam int MER_ST_MULTI = 32;
  localparam int MER_ST_PRIV = 31;
  localparam int MER_ST_STICKY_HI = 30;
  localparam int MER_ST_STICKY_LO = 20;
  localparam int MER_ST_TSYN_HI = 19;
  localparam int MER_ST_TSYN_LO = 16;
  localparam int MER_ST_PSYN_HI = 15;
  // Index of each event inside the eleven sticky bits.
  localparam int MER_EV_ISAP = 10;
  localparam int MER_EV_ETP = 9;
  localparam int MER_EV_IVUE = 8;
  localparam int MER_EV_TO = 7;
  localparam int MER_EV_BERR = 6;
  localparam int MER_EV_LDP = 5;
  localparam int MER_EV_CP = 4;
  localparam int MER_EV_WP = 3;
  localparam int MER_EV_EDP = 2;
  localparam int MER_EV_UE = 1;
  localparam int MER_EV_CE = 0;

  // ----------------------------------------
  // Reset values and trap codes
  // ----------------------------------------
  localparam logic [2:0] MER_ENABLE_RST = 3'h0;
  localparam logic [1:0] MER_LSU_RST = 2'h0;
  localparam logic [8:0] MER_TT_CORRECTED = 9'h063;
  localparam logic [5:0] MER_PRIO_DISRUPT = 6'h21;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MER_KIND_INSTR = 2'h0,
    MER_KIND_DATA = 2'h1,
    MER_KIND_WBACK = 2'h2,
    MER_KIND_SNOOP = 2'h3
  } mer_kind_type;

  typedef enum logic {
    MER_IDLE = 1'b0,
    MER_DRAIN = 1'b1
  } mer_state_type;

endpackage : mer_pkg
